// ### logic/pma_pkg.sv
`default_nettype none
// ==========================================================================
// Shared constants for the PHY management access block.
// ==========================================================================
package pma_pkg;
  // ========================================================================
  // Register byte offsets (low twelve address bits).
  // ========================================================================
  localparam logic [11:0] PMA_OFS_WDATA  = 12'h520; // Write data.
  localparam logic [11:0] PMA_OFS_ADDR   = 12'h524; // Target address.
  localparam logic [11:0] PMA_OFS_WRCMD  = 12'h528; // Write command.
  localparam logic [11:0] PMA_OFS_RDCMD  = 12'h52C; // Read command.
  localparam logic [11:0] PMA_OFS_RESULT = 12'h56C; // Read result.
  // ========================================================================
  // Reset values and field positions.
  // ========================================================================
  localparam logic [15:0] PMA_RST_WDATA  = 16'h0000;
  localparam logic [15:0] PMA_RST_ADDR   = 16'h0020;
  localparam logic [15:0] PMA_RST_RESULT = 16'h0000;
  localparam int          PMA_PHY_MSB    = 9;  // PHY address field top.
  localparam int          PMA_PHY_LSB    = 5;  // PHY address field bottom.
  localparam int          PMA_REG_MSB    = 4;  // Register field top.
  localparam int          PMA_CMD_BIT    = 0;  // Command bit position.
  // ========================================================================
  // Management frame layout, most significant bit sent first.
  // ========================================================================
  localparam int          PMA_FRAME_BITS = 64; // Preamble plus frame.
  localparam logic [31:0] PMA_PREAMBLE   = 32'hFFFFFFFF;
  localparam logic [1:0]  PMA_START      = 2'h1;
  localparam logic [1:0]  PMA_OP_WRITE   = 2'h1;
  localparam logic [1:0]  PMA_OP_READ    = 2'h2;
  localparam logic [1:0]  PMA_TURN       = 2'h2;
  localparam logic [6:0]  PMA_START_IDX  = 7'h20; // First start bit.
  localparam logic [6:0]  PMA_TURN_IDX   = 7'h2E; // First turnaround bit.
  localparam logic [6:0]  PMA_DATA_IDX   = 7'h30; // First data bit.
  localparam logic [6:0]  PMA_LAST_IDX   = 7'h3F; // Last data bit.
  // ========================================================================
  // Timing: transfer time and the link clock rate it is spread over.
  // ========================================================================
  localparam longint      PMA_XFER_TIME_NS = 82000;  // One transfer.
  localparam longint      PMA_LINK_CLK_KHZ = 166667; // Link clock rate.
  localparam int          PMA_MDC_HALF_CYC = int'((PMA_XFER_TIME_NS *
      PMA_LINK_CLK_KHZ) / (longint'(1000000) * 2 * PMA_FRAME_BITS));
  // AHB transfer type bit that marks NONSEQ or SEQ.
  localparam int          PMA_HTRANS_ACT = 1;
endpackage
`default_nettype wire

// ### logic/pma_mdio_engine.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Serial frame engine on the link clock: drives the management clock and
// shifts one frame per start event.
// ==========================================================================
module pma_mdio_engine #(
  parameter int unsigned HALF_CYC = pma_pkg::PMA_MDC_HALF_CYC
) (
  // Link clock and the device reset.
  input  wire logic        mgmt_clk,
  input  wire logic        hresetn,
  // Frame request from the register side, held stable while busy.
  input  wire logic        start_tgl,
  input  wire logic        op_read,
  input  wire logic [9:0]  frame_addr,
  input  wire logic [15:0] frame_wdata,
  // Completion back to the register side.
  output logic             done_tgl,
  output logic [15:0]      rdata,
  // Management pins.
  output logic             mdc,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe
);
  import pma_pkg::*;

  typedef enum logic {PMA_IDLE, PMA_SHIFT} pma_state_t;

  // Frame, bit and turnaround start, counted in link clock cycles.
  localparam int unsigned FRAME_CYC = 2 * PMA_FRAME_BITS * HALF_CYC;
  localparam int          BIT_CYC   = 2 * HALF_CYC;
  localparam int unsigned TURN_CYC  = 2 * PMA_TURN_IDX * HALF_CYC;

  logic        rst_s1_ff;    // Reset release synchroniser, first stage.
  logic        rst_s2_ff;    // Reset seen by link logic.
  logic        start_s1_ff;  // Start toggle, first stage.
  logic        start_s2_ff;  // Start toggle, synchronised.
  logic        start_s3_ff;  // Start toggle, delayed for edge detect.
  logic        mdio_s1_ff;   // Data pin, first stage.
  logic        mdio_s2_ff;   // Data pin, synchronised.
  pma_state_t  state_ff;     // Engine state.
  logic [15:0] half_cnt_ff;  // Cycles within a clock half.
  logic [6:0]  bit_cnt_ff;   // Bit index within the frame.
  logic [63:0] shift_ff;     // Outgoing frame, top bit on the pin.
  logic        mdc_ff;       // Management clock level.
  logic        read_ff;      // Current frame is a read.
  logic [15:0] rdata_ff;     // Bits gathered from the PHY.
  logic        done_tgl_ff;  // Toggles once per finished frame.
  logic [31:0] frame_cyc_ff; // Cycles spent in the current frame.
  logic        start_evt;    // One start request has arrived.
  logic        half_end;     // Last cycle of a clock half.

  // Reset is asserted at once and released in step with the link clock.
  always_ff @(posedge mgmt_clk or negedge hresetn) begin
    if (!hresetn) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  // Start toggle and data pin come from other domains.
  always_ff @(posedge mgmt_clk or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      start_s1_ff <= 1'b0;
      start_s2_ff <= 1'b0;
      start_s3_ff <= 1'b0;
      mdio_s1_ff  <= 1'b1;
      mdio_s2_ff  <= 1'b1;
    end else begin
      start_s1_ff <= start_tgl;
      start_s2_ff <= start_s1_ff;
      start_s3_ff <= start_s2_ff;
      mdio_s1_ff  <= mdio_i;
      mdio_s2_ff  <= mdio_s1_ff;
    end
  end

  assign start_evt = start_s2_ff ^ start_s3_ff;
  assign half_end  = (half_cnt_ff == 16'(HALF_CYC - 1));

  // Frame sequencer: data changes after the falling edge, the PHY
  // samples on the rising edge, and read bits are taken at the rise.
  always_ff @(posedge mgmt_clk or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      state_ff    <= PMA_IDLE;
      half_cnt_ff <= 16'h0000;
      bit_cnt_ff  <= 7'h00;
      shift_ff    <= 64'h0000000000000000;
      mdc_ff      <= 1'b0;
      read_ff     <= 1'b0;
      rdata_ff    <= 16'h0000;
      done_tgl_ff <= 1'b0;
    end else begin
      case (state_ff)
        PMA_IDLE: begin
          if (start_evt) begin
            // Clause 22 frame, data left zero on a read.
            state_ff    <= PMA_SHIFT;
            shift_ff    <= {PMA_PREAMBLE, PMA_START,
                            op_read ? PMA_OP_READ : PMA_OP_WRITE,
                            frame_addr, PMA_TURN,
                            op_read ? 16'h0000 : frame_wdata};
            bit_cnt_ff  <= 7'h00;
            half_cnt_ff <= 16'h0000;
            mdc_ff      <= 1'b0;
            read_ff     <= op_read;
          end
        end
        PMA_SHIFT: begin
          if (!half_end) begin
            half_cnt_ff <= half_cnt_ff + 16'h0001;
          end else if (!mdc_ff) begin
            // Rising edge: gather read data once the PHY drives.
            half_cnt_ff <= 16'h0000;
            mdc_ff      <= 1'b1;
            if (read_ff && bit_cnt_ff >= PMA_DATA_IDX) begin
              rdata_ff <= {rdata_ff[14:0], mdio_s2_ff};
            end
          end else begin
            // Falling edge: move to the next bit or finish.
            half_cnt_ff <= 16'h0000;
            mdc_ff      <= 1'b0;
            if (bit_cnt_ff == PMA_LAST_IDX) begin
              state_ff    <= PMA_IDLE;
              shift_ff    <= 64'h0000000000000000;
              done_tgl_ff <= ~done_tgl_ff;
            end else begin
              bit_cnt_ff <= bit_cnt_ff + 7'h01;
              shift_ff   <= {shift_ff[62:0], 1'b0};
            end
          end
        end
        default: begin
          state_ff <= PMA_IDLE;
        end
      endcase
    end
  end

  // Cycle count of the current frame, used only by the checks below.
  always_ff @(posedge mgmt_clk or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      frame_cyc_ff <= 32'h00000000;
    end else if (state_ff == PMA_IDLE) begin
      frame_cyc_ff <= 32'h00000000;
    end else begin
      frame_cyc_ff <= frame_cyc_ff + 32'h00000001;
    end
  end

  // The line is released from the turnaround onward on a read.
  assign mdio_oe  = (state_ff == PMA_SHIFT) &&
                    !(read_ff && bit_cnt_ff >= PMA_TURN_IDX);
  assign mdio_o   = shift_ff[63];
  assign mdc      = mdc_ff;
  assign done_tgl = done_tgl_ff;
  assign rdata    = rdata_ff;

  // ========================================================================
  // Checks.
  // ========================================================================
  default clocking cb @(posedge mgmt_clk); endclocking
  default disable iff (!rst_s2_ff);

  sequence s_last_fall;
    state_ff == PMA_SHIFT && half_end && mdc_ff &&
      bit_cnt_ff == PMA_LAST_IDX;
  endsequence

  sequence s_start_field;
    mdio_oe && !mdio_o ##BIT_CYC mdio_oe && mdio_o;
  endsequence

  a_frame_length: assert property (
    s_last_fall |-> frame_cyc_ff == 32'(FRAME_CYC - 1) ##1
      state_ff == PMA_IDLE && done_tgl_ff != $past(done_tgl_ff))
    else $error("Frame length differs from the transfer time.");

  a_read_release: assert property (
    state_ff == PMA_SHIFT && read_ff && frame_cyc_ff >= 32'(TURN_CYC)
      |-> !mdio_oe)
    else $error("Data line driven after the read turnaround.");

  a_start_bits: assert property (
    state_ff == PMA_SHIFT && bit_cnt_ff == PMA_START_IDX &&
      half_cnt_ff == 16'h0000 && !mdc_ff && $changed(bit_cnt_ff)
      |-> s_start_field)
    else $error("Start field not sent as zero then one.");
endmodule
`default_nettype wire

// ### logic/pma_top.sv
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Drive management clock and serial data line.
// - Sixteen-bit write data register feeds writes.
// - PHY address sits in bits nine to five.
// - Register number sits in bits four to zero.
// - Setting write bit starts a write frame.
// - Write bit clears itself when frame ends.
// - Write frame lasts about eighty-two microseconds.
// - Setting read bit fetches result register value.
// - Read bit clears itself when frame ends.
// - Read frame lasts about eighty-two microseconds.
module pma_top #(
  parameter int unsigned MDC_HALF_CYC = pma_pkg::PMA_MDC_HALF_CYC
) (
  // AHB-Lite clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave port.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Management link.
  input  wire logic        mgmt_clk,
  output logic             mdc,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe
);
  import pma_pkg::*;

  logic        dp_valid_ff;   // A data phase is pending.
  logic        dp_write_ff;   // Pending data phase is a write.
  logic [11:0] dp_addr_ff;    // Pending data phase address.
  logic [31:0] hrdata_ff;     // Read data for the pending phase.
  logic [31:0] nxt_hrdata;    // Read data chosen in the address phase.
  logic [15:0] wdata_ff;      // Write data register.
  logic [9:0]  addr_ff;       // Target address register, used bits.
  logic        wr_cmd_ff;     // Write command bit.
  logic        rd_cmd_ff;     // Read command bit.
  logic [15:0] result_ff;     // Read result register.
  logic        start_tgl_ff;  // Toggles once per accepted command.
  logic        op_read_ff;    // Current frame is a read.
  logic [9:0]  frame_addr_ff; // Address frozen for the frame.
  logic [15:0] frame_wd_ff;   // Write data frozen for the frame.
  logic        done_s1_ff;    // Done toggle, first stage.
  logic        done_s2_ff;    // Done toggle, synchronised.
  logic        done_s3_ff;    // Done toggle, delayed for edge detect.
  logic        done_tgl;      // Done toggle from the link domain.
  logic [15:0] link_rdata;    // Read value held by the link domain.
  logic        addr_phase;    // An address phase is taken this edge.
  logic        wr_en;         // Register write in this data phase.
  logic        busy;          // A frame is outstanding.
  logic        done_evt;      // One frame has finished.
  logic        wr_start;      // Software starts a write frame.
  logic        rd_start;      // Software starts a read frame.

  // ========================================================================
  // AHB-Lite slave: no wait states, always OKAY.
  // ========================================================================
  assign addr_phase = hsel && hready && htrans[PMA_HTRANS_ACT];
  assign wr_en      = dp_valid_ff && dp_write_ff;

  // The address phase is captured so the write lands in its data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_ff <= 1'b0;
      dp_write_ff <= 1'b0;
      dp_addr_ff  <= 12'h000;
    end else if (hready) begin
      dp_valid_ff <= addr_phase;
      dp_write_ff <= hwrite;
      dp_addr_ff  <= haddr[11:0];
    end
  end

  // Read data is chosen from the address phase; unmapped reads give zero.
  always_comb begin
    nxt_hrdata = 32'h00000000;
    if (haddr[11:0] == PMA_OFS_WDATA) begin
      nxt_hrdata = {16'h0000, wdata_ff};
    end else if (haddr[11:0] == PMA_OFS_ADDR) begin
      nxt_hrdata = {22'h000000, addr_ff};
    end else if (haddr[11:0] == PMA_OFS_WRCMD) begin
      nxt_hrdata = {31'h00000000, wr_cmd_ff};
    end else if (haddr[11:0] == PMA_OFS_RDCMD) begin
      nxt_hrdata = {31'h00000000, rd_cmd_ff};
    end else if (haddr[11:0] == PMA_OFS_RESULT) begin
      nxt_hrdata = {16'h0000, result_ff};
    end
  end

  // Read data register, loaded only for a taken read.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      hrdata_ff <= nxt_hrdata;
    end
  end

  // No wait states and no error responses: every transfer is OKAY.
  assign hrdata    = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ========================================================================
  // Software registers.
  // ========================================================================
  // Write data and target address; only the low ten address bits exist.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdata_ff <= PMA_RST_WDATA;
      addr_ff  <= PMA_RST_ADDR[9:0];
    end else if (wr_en && dp_addr_ff == PMA_OFS_WDATA) begin
      wdata_ff <= hwdata[15:0];
    end else if (wr_en && dp_addr_ff == PMA_OFS_ADDR) begin
      addr_ff  <= hwdata[PMA_PHY_MSB:0];
    end
  end

  // A frame is outstanding while either command bit is set; a new
  // start is refused until the frame's end has crossed back.
  assign busy     = wr_cmd_ff || rd_cmd_ff;
  assign done_evt = done_s2_ff ^ done_s3_ff;
  assign wr_start = wr_en && dp_addr_ff == PMA_OFS_WRCMD &&
                    hwdata[PMA_CMD_BIT] && !busy;
  assign rd_start = wr_en && dp_addr_ff == PMA_OFS_RDCMD &&
                    hwdata[PMA_CMD_BIT] && !busy;

  // Command bits: a one starts a frame when idle; writes while busy and
  // writes of zero are ignored, so only the end of a frame clears them.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_cmd_ff <= 1'b0;
      rd_cmd_ff <= 1'b0;
    end else if (done_evt) begin
      wr_cmd_ff <= 1'b0;
      rd_cmd_ff <= 1'b0;
    end else if (wr_start) begin
      wr_cmd_ff <= 1'b1;
    end else if (rd_start) begin
      rd_cmd_ff <= 1'b1;
    end
  end

  // A start freezes address and data so the frame sees stable words.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_tgl_ff  <= 1'b0;
      op_read_ff    <= 1'b0;
      frame_addr_ff <= 10'h000;
      frame_wd_ff   <= 16'h0000;
    end else if (wr_start || rd_start) begin
      start_tgl_ff  <= ~start_tgl_ff;
      op_read_ff    <= rd_start;
      frame_addr_ff <= addr_ff;
      frame_wd_ff   <= wdata_ff;
    end
  end

  // ========================================================================
  // Return path from the link domain.
  // ========================================================================
  // The done toggle crosses two stages; the read value is already stable.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_s1_ff <= 1'b0;
      done_s2_ff <= 1'b0;
      done_s3_ff <= 1'b0;
    end else begin
      done_s1_ff <= done_tgl;
      done_s2_ff <= done_s1_ff;
      done_s3_ff <= done_s2_ff;
    end
  end

  // The result register takes the PHY's word when a read frame ends.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_ff <= PMA_RST_RESULT;
    end else if (done_evt && rd_cmd_ff) begin
      result_ff <= link_rdata;
    end
  end

  // ========================================================================
  // Serial engine on the link clock.
  // ========================================================================
  // Address and data cross frozen, so only the start toggle needs a
  // synchroniser on the link side.
  pma_mdio_engine #(
    .HALF_CYC (MDC_HALF_CYC)
  ) u_engine (
    .mgmt_clk    (mgmt_clk),
    .hresetn     (hresetn),
    .start_tgl   (start_tgl_ff),
    .op_read     (op_read_ff),
    .frame_addr  (frame_addr_ff),
    .frame_wdata (frame_wd_ff),
    .done_tgl    (done_tgl),
    .rdata       (link_rdata),
    .mdc         (mdc),
    .mdio_i      (mdio_i),
    .mdio_o      (mdio_o),
    .mdio_oe     (mdio_oe)
  );

  // ========================================================================
  // Checks.
  // ========================================================================
  // All checks below watch the register clock domain.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // A command write of one that the idle block must take.
  sequence s_cmd_write(logic [11:0] ofs);
    wr_en && dp_addr_ff == ofs && hwdata[PMA_CMD_BIT] && !busy;
  endsequence

  a_wr_cmd_start: assert property (
    s_cmd_write(PMA_OFS_WRCMD) |=> wr_cmd_ff && !op_read_ff &&
      start_tgl_ff != $past(start_tgl_ff))
    else $error("Write command did not start a frame.");

  a_rd_cmd_start: assert property (
    s_cmd_write(PMA_OFS_RDCMD) |=> rd_cmd_ff && op_read_ff &&
      start_tgl_ff != $past(start_tgl_ff))
    else $error("Read command did not start a frame.");

  a_wr_cmd_hold: assert property (
    wr_cmd_ff && !done_evt |=> wr_cmd_ff)
    else $error("Write command fell before the frame ended.");

  a_wr_self_clr: assert property (
    wr_cmd_ff && done_evt |=> !wr_cmd_ff ##1 !wr_cmd_ff || $past(wr_en))
    else $error("Write command not cleared at frame end.");

  a_rd_self_clr: assert property (
    rd_cmd_ff && done_evt |=> !rd_cmd_ff &&
      result_ff == $past(link_rdata))
    else $error("Read end did not clear bit and load result.");

  a_wdata_store: assert property (
    wr_en && dp_addr_ff == PMA_OFS_WDATA |=>
      wdata_ff == $past(hwdata[15:0]) ##1 hrdata_ff[31:16] == 16'h0000)
    else $error("Write data register did not take the bus word.");

  a_addr_freeze: assert property (
    (wr_start || rd_start) |=>
      frame_addr_ff[PMA_PHY_MSB:PMA_PHY_LSB] ==
        $past(addr_ff[PMA_PHY_MSB:PMA_PHY_LSB]) &&
      frame_addr_ff[PMA_REG_MSB:0] == $past(addr_ff[PMA_REG_MSB:0]))
    else $error("Frame address differs from the address register.");

  // Only one frame may be outstanding at any time.
  a_one_frame: assert property (
    !(wr_cmd_ff && rd_cmd_ff))
    else $error("Both command bits set at once.");

  // Command writes during a frame leave the engine alone.
  a_busy_refuse: assert property (
    busy && wr_en && (dp_addr_ff == PMA_OFS_WRCMD ||
      dp_addr_ff == PMA_OFS_RDCMD) |=>
      start_tgl_ff == $past(start_tgl_ff))
    else $error("A command was taken while a frame was running.");

  // The result only changes when a read frame ends.
  a_result_hold: assert property (
    !(done_evt && rd_cmd_ff) |=> $stable(result_ff))
    else $error("Read result changed outside a read frame end.");

  // A result read returns the register in its data phase.
  a_result_read: assert property (
    addr_phase && !hwrite && haddr[11:0] == PMA_OFS_RESULT |=>
      hrdata == {16'h0000, $past(result_ff)})
    else $error("Result read did not return the result register.");

  a_hrdata_hold: assert property (
    !(addr_phase && !hwrite) |=> $stable(hrdata))
    else $error("Read data moved without a new read.");

  // A write of zero to the write command never starts a frame.
  a_zero_ignored: assert property (
    wr_en && dp_addr_ff == PMA_OFS_WRCMD && !hwdata[PMA_CMD_BIT] &&
      !busy |=> !wr_cmd_ff)
    else $error("A write of zero started a write frame.");
endmodule
`default_nettype wire

// ### sim/pma_phy_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// PHY end of the management link.
// ==========================================
module pma_phy_model (
  // Management clock, reset and line level.
  input  wire logic        mdc,
  input  wire logic        rst_n,
  input  wire logic        line,
  input  wire logic [15:0] rd_val,
  // Line drive back to the device.
  output logic             phy_oe,
  output logic             phy_o,
  // Last whole frame and its toggle.
  output logic [63:0]      frame,
  output logic             fr_tgl
);
  logic [5:0]  cnt; // Rising edges seen in this frame.
  logic [63:0] sr;  // Bits sampled so far.
  logic        rd;  // Current frame is a read.
  // Sample the line on each rising edge, MSB first.
  always @(posedge mdc or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 6'h00;
      fr_tgl <= 1'b0;
    end else begin
      sr <= {sr[62:0], line};
      cnt <= cnt + 6'h01;
      if (cnt == 6'h3F) begin
        frame <= {sr[62:0], line};
        fr_tgl <= ~fr_tgl;
      end
    end
  end
  // Take the line at the second turnaround bit on reads, release at frame end.
  always @(negedge mdc or negedge rst_n) begin
    if (!rst_n) begin
      phy_oe <= 1'b0;
      rd <= 1'b0;
    end else if (cnt == 6'h2F) begin
      rd <= (sr[12:11] == 2'h2);
      phy_oe <= (sr[12:11] == 2'h2);
      phy_o <= 1'b0;
    end else if (cnt >= 6'h30 && rd) begin
      phy_o <= rd_val[~cnt[3:0]];
    end else begin
      phy_oe <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### sim/tb_phy_management_access.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Bench for the management access block.
// ==========================================
module tb_phy_management_access;
  import pma_pkg::*;
  localparam int H = 4;   // Shortened management half period.
  logic        hclk = 0, mgmt_clk = 0, hresetn = 0, chk = 0, fr_seen = 0;
  logic        hsel = 0, hwrite = 0, hresp, hreadyout;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, v;
  logic        mdc, mdio_o, mdio_oe, phy_oe, phy_o, fr_tgl, mdio_w;
  logic [15:0] rd_val = 0;
  logic [63:0] frame, exp_q[$], frm_q[$];
  int          n_fail = 0, cmp_count = 0, cyc = 0;
  // Clocks of unrelated phase.
  always #2 hclk = ~hclk;
  initial begin
    #1.3;
    forever #3 mgmt_clk = ~mgmt_clk;
  end
  // Shared line with a pull-up when nobody drives it.
  assign mdio_w = mdio_oe ? mdio_o : (phy_oe ? phy_o : 1'b1);
  pma_top #(.MDC_HALF_CYC(H)) pma_top_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mgmt_clk(mgmt_clk), .mdc(mdc),
    .mdio_i(mdio_w), .mdio_o(mdio_o), .mdio_oe(mdio_oe));
  pma_phy_model pma_phy_model_i (.mdc(mdc), .rst_n(hresetn), .line(mdio_w),
    .rd_val(rd_val), .phy_oe(phy_oe), .phy_o(phy_o), .frame(frame),
    .fr_tgl(fr_tgl));
  // ==========================================
  // Checking.
  // ==========================================
  // Compare a result with the oldest expectation.
  task cmp(input logic [63:0] got, input logic [63:0] e);
    cmp_count++;
    if (got !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, e);
    end
  endtask
  // Watch read data phases and finished frames.
  always @(posedge hclk) if (chk && hreadyout)
    cmp({31'h0, hresp, hrdata}, exp_q.size() ? exp_q.pop_front() : 'x);
  always @(posedge hclk) begin
    fr_seen <= fr_tgl;
    if (fr_tgl !== fr_seen)
      cmp(frame, frm_q.size() ? frm_q.pop_front() : 'x);
  end
  // Print the counts and the verdict, then stop.
  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Cut a hang short.
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out;
    end
  end
  // ==========================================
  // Bus tasks.
  // ==========================================
  // One single AHB-Lite word transfer.
  task bus(input logic [11:0] a, input logic w, input logic [31:0] d,
           input logic c, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    chk <= c & ~w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, 1'b0, q);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    exp_q.push_back({32'h0, e});
    bus(a, 1'b0, 32'h0, 1'b1, q);
  endtask
  // One management transfer, checked on the wire and in the registers.
  task xfer(input logic op, input logic [9:0] a, input logic [15:0] d);
    logic [11:0] own, oth;
    logic [31:0] q;
    int          t0;
    own = op ? PMA_OFS_RDCMD : PMA_OFS_WRCMD;
    oth = op ? PMA_OFS_WRCMD : PMA_OFS_RDCMD;
    rd_val <= d;
    wr(PMA_OFS_ADDR, {22'h0, a});
    wr(PMA_OFS_WDATA, {16'h0, d});
    frm_q.push_back({32'hFFFFFFFF, 2'h1, op ? 2'h2 : 2'h1, a, 2'h2, d});
    t0 = cyc;
    wr(own, 32'h1);
    wr(oth, 32'h1);
    rd(own, 32'h1);
    rd(oth, 32'h0);
    do bus(own, 1'b0, 32'h0, 1'b0, q); while (q[0] === 1'b1);
    cmp(64'(cyc - t0 >= 192 * H && cyc - t0 <= 192 * H + 52),
        64'h1);
    repeat (1250) @(posedge hclk);
    if (op) rd(PMA_OFS_RESULT, {16'h0, d});
    $display("test transfer op %0d done", op);
  endtask
  // ==========================================
  // Main sequence.
  // ==========================================
  initial begin
    void'($urandom(32'h279AB8AB));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(PMA_OFS_WDATA, 32'h0);
    rd(PMA_OFS_ADDR, 32'h20);
    rd(PMA_OFS_WRCMD, 32'h0);
    rd(PMA_OFS_RDCMD, 32'h0);
    rd(PMA_OFS_RESULT, 32'h0);
    rd(12'h530, 32'h0);
    $display("test reset values done");
    v = $urandom;
    wr(PMA_OFS_ADDR, v);
    rd(PMA_OFS_ADDR, v & 32'h3FF);
    wr(PMA_OFS_WDATA, v);
    rd(PMA_OFS_WDATA, v & 32'hFFFF);
    wr(PMA_OFS_RESULT, ~v);
    rd(PMA_OFS_RESULT, 32'h0);
    wr(PMA_OFS_WRCMD, 32'h2);
    rd(PMA_OFS_WRCMD, 32'h0);
    $display("test register access done");
    for (int i = 0; i < 4; i++) xfer(i[0], 10'($urandom), 16'($urandom));
    close_out;
  end
endmodule
`default_nettype wire
